// ==== cdv_consts.svh ====
`ifndef CDV_CONSTS_SVH
`define CDV_CONSTS_SVH
// ==========================================================
// Register bus geometry
`define CDV_ADDR_W        10
`define CDV_DATA_W        8
// ==========================================================
// Register offsets
`define CDV_OFF_CNT1      10'h19e
`define CDV_OFF_PHASE     10'h19f
`define CDV_OFF_CNT2      10'h1a0
`define CDV_OFF_CTRL      10'h1a1
`define CDV_OFF_DCC       10'h1a2
`define CDV_OFF_VDIV      10'h1e0
`define CDV_OFF_CLKIN     10'h1e1
`define CDV_OFF_SYNC      10'h230
`define CDV_OFF_UPDATE    10'h232
`define CDV_OFF_STATUS    10'h233
// ==========================================================
// Reset values
`define CDV_RST_ZERO      8'h00
`define CDV_RST_VDIV      8'h02
// ==========================================================
// Field positions
`define CDV_LOW_HI        7
`define CDV_LOW_LO        4
`define CDV_HIGH_HI       3
`define CDV_HIGH_LO       0
`define CDV_PH2_HI        7
`define CDV_PH2_LO        4
`define CDV_PH1_HI        3
`define CDV_PH1_LO        0
`define CDV_BYP2_BIT      5
`define CDV_BYP1_BIT      4
`define CDV_NOSYNC_BIT    3
`define CDV_FORCE_BIT     2
`define CDV_START2_BIT    1
`define CDV_START1_BIT    0
`define CDV_DUTY_CORRECTION_DISABLE_BIT    0
`define CDV_VDIV_HI       2
`define CDV_VDIV_LO       0
`define CDV_PD_IN_BIT     4
`define CDV_PD_VIF_BIT    3
`define CDV_PD_BOTH_BIT   2
`define CDV_SEL_VCO_BIT   1
`define CDV_VBYP_BIT      0
`define CDV_SOFT_SYNC_BIT 0
`define CDV_UPDATE_BIT    0
// ==========================================================
// Divider constants
`define CDV_VDIV_BASE     3'h2
`define CDV_VDIV_LAST     3'h4
`endif

// ==== cdv_pkg.sv ====
package cdv_pkg;
  // Full configuration image, buffer or active copy
  typedef struct packed {
    logic [7:0] first_counts;   // Low/high counts, first sub-divider
    logic [7:0] phase;          // Phase offsets, both sub-dividers
    logic [7:0] second_counts;  // Low/high counts, second sub-divider
    logic [7:0] ctrl;           // Bypass, sync ignore, force, start levels
    logic [7:0] dcc;            // Duty correction disable
    logic [7:0] vco_ratio;      // VCO divider code
    logic [7:0] clk_in;         // Input select and power-downs
    logic [7:0] sync_ctl;       // Soft sync
  } cdv_cfg_type;
endpackage

// ==== cdv_channel_divider.sv ====
`timescale 1ns/1ps
`include "cdv_consts.svh"

// Function
// - Output low for low field plus one
// - Output high for high field plus one
// - Per-stage phase offset delays start
// - Bypass passes input clock straight through
// - Sync ignore bit masks chip sync
// - Force bit sets static level with nosync
// - Start level bit picks first level
// - Duty correction unless disable bit set
// - VCO code selects divide two to six
// - Input section power-down stops clock tree
// - VCO interface power-down gates VCO
// - Select bit picks VCO or external clock
// - Bypass bit routes around VCO divider
// - Update bit copies buffers to active
// - Soft sync high holds, falling edge syncs
module cdv_channel_divider (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [`CDV_ADDR_W-1:0] addr,
  input  wire logic [`CDV_DATA_W-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output      logic [`CDV_DATA_W-1:0] rdata,
  input  wire logic                   vco_in,
  input  wire logic                   ext_clk_in,
  input  wire logic                   sync_n,
  output      logic                   vco_div_out,
  output      logic                   chan_out
);

  // ==========================================================
  // Configuration storage
  cdv_pkg::cdv_cfg_type buf_reg;     // Software-written copy
  cdv_pkg::cdv_cfg_type act_reg;     // Copy that steers the logic
  logic                 update_reg;  // Pending transfer pulse

  // Buffer writes; registers take the byte as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_reg           <= '0;
      buf_reg.vco_ratio <= `CDV_RST_VDIV;
    end else if (wr) begin
      unique case (addr)
        `CDV_OFF_CNT1:  buf_reg.first_counts  <= wdata;
        `CDV_OFF_PHASE: buf_reg.phase         <= wdata;
        `CDV_OFF_CNT2:  buf_reg.second_counts <= wdata;
        `CDV_OFF_CTRL:  buf_reg.ctrl          <= wdata;
        `CDV_OFF_DCC:   buf_reg.dcc           <= wdata;
        `CDV_OFF_VDIV:  buf_reg.vco_ratio     <= wdata;
        `CDV_OFF_CLKIN: buf_reg.clk_in        <= wdata;
        `CDV_OFF_SYNC:  buf_reg.sync_ctl      <= wdata;
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Update bit self-clears the cycle after it is written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      update_reg <= 1'b0;
    end else begin
      update_reg <= wr && (addr == `CDV_OFF_UPDATE) && wdata[`CDV_UPDATE_BIT];
    end
  end

  // Active copy follows buffer only on update, so a group of writes lands at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_reg           <= '0;
      act_reg.vco_ratio <= `CDV_RST_VDIV;
    end else if (update_reg) begin
      act_reg <= buf_reg;
    end
  end

  // ==========================================================
  // Field decode of the active copy
  logic [2:0] vdiv_code;
  logic       pd_in;
  logic       pd_vif;
  logic       pd_both;
  logic       sel_vco;
  logic       vco_bypass;
  logic       nosync;
  logic       force_high;
  logic       dcc_on;
  logic       soft_sync;

  assign vdiv_code  = act_reg.vco_ratio[`CDV_VDIV_HI:`CDV_VDIV_LO];
  assign pd_in      = act_reg.clk_in[`CDV_PD_IN_BIT];
  assign pd_vif     = act_reg.clk_in[`CDV_PD_VIF_BIT];
  assign pd_both    = act_reg.clk_in[`CDV_PD_BOTH_BIT];
  assign sel_vco    = act_reg.clk_in[`CDV_SEL_VCO_BIT];
  assign vco_bypass = act_reg.clk_in[`CDV_VBYP_BIT];
  assign nosync     = act_reg.ctrl[`CDV_NOSYNC_BIT];
  assign force_high = act_reg.ctrl[`CDV_FORCE_BIT];
  assign dcc_on     = ~act_reg.dcc[`CDV_DUTY_CORRECTION_DISABLE_BIT];
  assign soft_sync  = act_reg.sync_ctl[`CDV_SOFT_SYNC_BIT];

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  logic [1:0] vco_sync_reg;
  logic [1:0] ext_sync_reg;
  logic [1:0] syncn_sync_reg;

  // Two flip-flops per pin; clocks are sampled as levels, so they must be slow
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vco_sync_reg   <= 2'h0;
      ext_sync_reg   <= 2'h0;
      syncn_sync_reg <= 2'h3;
    end else begin
      vco_sync_reg   <= {vco_sync_reg[0], vco_in};
      ext_sync_reg   <= {ext_sync_reg[0], ext_clk_in};
      syncn_sync_reg <= {syncn_sync_reg[0], sync_n};
    end
  end

  // ==========================================================
  // Source selection and power-down gating
  logic src_lvl;
  logic sync_req;
  logic hold;

  always_comb begin
    if (pd_in || pd_both) begin
      src_lvl = 1'b0;
    end else if (sel_vco) begin
      src_lvl = vco_sync_reg[1] & ~pd_vif;
    end else begin
      src_lvl = ext_sync_reg[1];
    end
  end

  // Soft sync acts like an inverted sync pin; dividers start only once both are released
  assign sync_req = ~syncn_sync_reg[1] | soft_sync;
  // Powered-down clock tree also keeps dividers parked
  assign hold     = (sync_req & ~nosync) | pd_in;

  // ==========================================================
  // VCO divider: divide by code plus two, codes above four static
  logic       vsrc_prev_reg;
  logic [2:0] vcnt_reg;
  logic       vlvl_reg;
  logic [2:0] vratio;
  logic [2:0] vhalf_hi;
  logic [2:0] vhalf_lo;
  logic       vrise;

  assign vratio   = vdiv_code + `CDV_VDIV_BASE;
  assign vhalf_hi = {1'b0, vratio[2:1]};
  assign vhalf_lo = vratio - vhalf_hi;
  assign vrise    = src_lvl & ~vsrc_prev_reg;

  // Counter over source rising edges; low half takes the odd extra cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vsrc_prev_reg <= 1'b0;
      vcnt_reg      <= 3'h0;
      vlvl_reg      <= 1'b0;
    end else begin
      vsrc_prev_reg <= src_lvl;
      if (pd_in || pd_both || (vdiv_code > `CDV_VDIV_LAST)) begin
        vcnt_reg <= 3'h0;
        vlvl_reg <= 1'b0;
      end else if (vrise) begin
        if (vcnt_reg == ((vlvl_reg ? vhalf_hi : vhalf_lo) - 3'h1)) begin
          vcnt_reg <= 3'h0;
          vlvl_reg <= ~vlvl_reg;
        end else begin
          vcnt_reg <= vcnt_reg + 3'h1;
        end
      end
    end
  end

  // Distribution clock: divided or routed around the VCO divider
  logic dist_lvl;
  assign dist_lvl = pd_in ? 1'b0 : (vco_bypass ? src_lvl : vlvl_reg);

  // Registered copy of the distribution clock, divided or routed around the VCO divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vco_div_out <= 1'b0;
    end else begin
      vco_div_out <= dist_lvl;
    end
  end

  // ==========================================================
  // Two cascaded channel sub-dividers
  logic [1:0] stage_in;
  logic [1:0] stage_lvl;
  logic [7:0] stage_counts [2];

  assign stage_in[0]     = dist_lvl;
  assign stage_in[1]     = stage_lvl[0];
  assign stage_counts[0] = act_reg.first_counts;
  assign stage_counts[1] = act_reg.second_counts;

  for (genvar gi = 0; gi < 2; gi++) begin : g_stage
    logic       prev_reg;   // Input level last cycle
    logic [4:0] cnt_reg;    // Cycles spent in current level
    logic [3:0] ph_reg;     // Remaining phase delay cycles
    logic       lvl_reg;    // Stage output level
    logic       bypass;
    logic       start_hi;
    logic [3:0] phase;
    logic [4:0] low_n;      // Low cycles
    logic [4:0] high_n;     // High cycles
    logic [5:0] total;      // Sum reaches 32, so six bits
    logic [4:0] low_eff;
    logic [4:0] high_eff;
    logic       rise;

    assign bypass   = act_reg.ctrl[gi == 0 ? `CDV_BYP1_BIT : `CDV_BYP2_BIT];
    assign start_hi = act_reg.ctrl[gi == 0 ? `CDV_START1_BIT : `CDV_START2_BIT];
    assign phase    = (gi == 0) ? act_reg.phase[`CDV_PH1_HI:`CDV_PH1_LO]
                                : act_reg.phase[`CDV_PH2_HI:`CDV_PH2_LO];
    assign low_n    = {1'b0, stage_counts[gi][`CDV_LOW_HI:`CDV_LOW_LO]} + 5'h01;
    assign high_n   = {1'b0, stage_counts[gi][`CDV_HIGH_HI:`CDV_HIGH_LO]} + 5'h01;
    assign total    = {1'b0, low_n} + {1'b0, high_n};
    // Correction evens the split but keeps the ratio; odd ratios give low the extra cycle
    assign high_eff = dcc_on ? total[5:1] : high_n;
    assign low_eff  = dcc_on ? 5'(total - {1'b0, total[5:1]}) : low_n;
    assign rise     = stage_in[gi] & ~prev_reg;
    assign stage_lvl[gi] = lvl_reg;

    // Level machine: park on sync, pass through on bypass, else count edges
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        prev_reg <= 1'b0;
        cnt_reg  <= 5'h00;
        ph_reg   <= 4'h0;
        lvl_reg  <= 1'b0;
      end else begin
        prev_reg <= stage_in[gi];
        if (hold) begin
          cnt_reg <= 5'h00;
          ph_reg  <= phase;
          lvl_reg <= start_hi;
        end else if (bypass) begin
          cnt_reg <= 5'h00;
          lvl_reg <= stage_in[gi];
        end else if (rise) begin
          if (ph_reg != 4'h0) begin
            ph_reg <= ph_reg - 4'h1;
          end else if (cnt_reg == ((lvl_reg ? high_eff : low_eff) - 5'h01)) begin
            cnt_reg <= 5'h00;
            lvl_reg <= ~lvl_reg;
          end else begin
            cnt_reg <= cnt_reg + 5'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // Channel output: force with sync ignored, dead when powered down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_out <= 1'b0;
    end else if (pd_in) begin
      chan_out <= 1'b0;
    end else if (nosync && force_high) begin
      chan_out <= 1'b1;
    end else begin
      chan_out <= stage_lvl[1];
    end
  end

  // ==========================================================
  // Read path: data stands in the cycle after the strobe only
  logic [`CDV_DATA_W-1:0] rd_mux;

  // Buffers read back what software wrote; status shows live state
  always_comb begin
    unique case (addr)
      `CDV_OFF_CNT1:   rd_mux = buf_reg.first_counts;
      `CDV_OFF_PHASE:  rd_mux = buf_reg.phase;
      `CDV_OFF_CNT2:   rd_mux = buf_reg.second_counts;
      `CDV_OFF_CTRL:   rd_mux = buf_reg.ctrl;
      `CDV_OFF_DCC:    rd_mux = buf_reg.dcc;
      `CDV_OFF_VDIV:   rd_mux = buf_reg.vco_ratio;
      `CDV_OFF_CLKIN:  rd_mux = buf_reg.clk_in;
      `CDV_OFF_SYNC:   rd_mux = buf_reg.sync_ctl;
      `CDV_OFF_STATUS: rd_mux = {3'h0, hold, chan_out, stage_lvl[1], stage_lvl[0], vlvl_reg};
      default:         rd_mux = `CDV_RST_ZERO; // Update bit and unmapped read zero
    endcase
  end

  // Read data register, zero outside the answer cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `CDV_RST_ZERO;
    end else begin
      rdata <= rd ? rd_mux : `CDV_RST_ZERO;
    end
  end

endmodule

// ==== cdv_channel_divider_props.sv ====
`timescale 1ns/1ps
`include "cdv_consts.svh"
module cdv_channel_divider_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       vco_in,
  input wire logic       ext_clk_in,
  input wire logic       sync_n,
  input wire logic       vco_div_out,
  input wire logic       chan_out
);
  // ==========================================================
  // Shadow copies, buffer and active, of the fields we judge
  logic [7:0] bc_reg, bv_reg, bi_reg;  // Buffered ctrl, ratio, clock input
  logic [7:0] ac_reg, av_reg, ai_reg;  // Active copies after update
  // Copy on update write; runs a cycle early, windows below allow it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {bc_reg, bi_reg, ac_reg, ai_reg} <= 32'h0;
      bv_reg <= 8'h02;
      av_reg <= 8'h02;
    end else if (wr) begin
      if (addr == `CDV_OFF_CTRL) bc_reg <= wdata;
      if (addr == `CDV_OFF_VDIV) bv_reg <= wdata;
      if (addr == `CDV_OFF_CLKIN) bi_reg <= wdata;
      if (addr == `CDV_OFF_UPDATE && wdata[0]) begin
        {ac_reg, av_reg, ai_reg} <= {bc_reg, bv_reg, bi_reg};
      end
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RD_IDLE_ZERO: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  AST_UPDATE_READS_ZERO: assert property (rd && addr == `CDV_OFF_UPDATE |=> rdata == 8'h00)
    else $error("update bit did not read back clear");
  AST_RESET_OUT: assert property (disable iff (1'b0) !rstn |-> !chan_out && !vco_div_out && rdata == 8'h00)
    else $error("outputs not low in reset");
  AST_BUF_READBACK: assert property (wr && addr == `CDV_OFF_CTRL ##2 rd && addr == `CDV_OFF_CTRL
    |=> rdata == $past(wdata, 3))
    else $error("buffer readback differs from write");
  AST_FORCE_HIGH: assert property ((ac_reg[3] && ac_reg[2] && !ai_reg[4])[*6] |-> chan_out)
    else $error("forced output not high");
  AST_PD_LOW: assert property (ai_reg[4][*6] |-> !chan_out && !vco_div_out)
    else $error("powered down outputs not low");
  AST_VDIV_STATIC: assert property ((av_reg[2:0] > 3'h4 && !ai_reg[0])[*6] |-> !vco_div_out)
    else $error("static ratio code still toggling");
  AST_SYNC_HOLD: assert property ((!sync_n && !ac_reg[3] && !ac_reg[5] && !ai_reg[4])[*8]
    |-> chan_out == ac_reg[1])
    else $error("sync hold not at start level");
endmodule

// ==== cdv_channel_divider_tb_top.sv ====
`timescale 1ns/1ps
`include "cdv_consts.svh"
module cdv_channel_divider_tb_top;
  // ==========================================================
  // Signals
  logic       clk, rstn, wr, rd, sync_n, vco_div_out, chan_out;
  logic       vco_in = 1'b0;      // Sources start low, then only the cycle counter drives them
  logic       ext_clk_in = 1'b0;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, v, d;
  logic [9:0] offs [8];  // Every buffered register
  int         n_mismatch, tests_run, hi, lo, tg;
  int         cyc = 0;            // Free cycle count, paces sources and timeout
  cdv_channel_divider dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .vco_in(vco_in), .ext_clk_in(ext_clk_in), .sync_n(sync_n),
    .vco_div_out(vco_div_out), .chan_out(chan_out));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sources: external period 8 cycles, VCO 12; timeout guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) ext_clk_in <= ~ext_clk_in;
    if (cyc % 6 == 5) vco_in <= ~vco_in;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // Whole image then update, since update copies every buffer
  task cfg(input logic [7:0] c1, c2, ct, dc, vd, ci, sy);
    wreg(`CDV_OFF_CNT1, c1); wreg(`CDV_OFF_PHASE, 8'h00); wreg(`CDV_OFF_CNT2, c2);
    wreg(`CDV_OFF_CTRL, ct); wreg(`CDV_OFF_DCC, dc); wreg(`CDV_OFF_VDIV, vd);
    wreg(`CDV_OFF_CLKIN, ci); wreg(`CDV_OFF_SYNC, sy); wreg(`CDV_OFF_UPDATE, 8'h01);
    repeat (40) @(posedge clk);
  endtask
  function logic sig(input bit s);
    return s ? vco_div_out : chan_out;
  endfunction
  // High and low time of one period, in clock cycles
  task meas(input bit s);
    int k;
    hi = 0; lo = 0; k = 0;
    while (sig(s) !== 1'b0 && k < 600) begin @(negedge clk); k++; end
    while (sig(s) !== 1'b1 && k < 600) begin @(negedge clk); k++; end
    while (sig(s) === 1'b1 && k < 600) begin @(negedge clk); k++; hi++; end
    while (sig(s) === 1'b0 && k < 600) begin @(negedge clk); k++; lo++; end
  endtask
  task quiet(input bit s);
    logic l;
    l = sig(s); tg = 0;
    repeat (100) begin
      @(negedge clk);
      if (sig(s) !== l) tg++;
      l = sig(s);
    end
  endtask
  // Expected stage high time on the 8-cycle source; correction splits the whole ratio
  function int exp_hi(input logic [7:0] c, input bit dcc);
    int t;
    t = int'(c[3:0]) + int'(c[7:4]) + 2;
    return dcc ? (t / 2) * 8 : (int'(c[3:0]) + 1) * 8;
  endfunction
  // Expected stage low time; low takes the odd cycle under correction
  function int exp_lo(input logic [7:0] c, input bit dcc);
    int t;
    t = int'(c[3:0]) + int'(c[7:4]) + 2;
    return dcc ? (t - t / 2) * 8 : (int'(c[7:4]) + 1) * 8;
  endfunction
  // Park on sync, release at a fixed source phase, count cycles to first high
  task rel(output int n);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (20) @(posedge clk);
    while (cyc % 8 != 0) @(posedge clk);
    sync_n <= 1'b1;
    n = 0;
    while (chan_out !== 1'b1 && n < 300) begin @(negedge clk); n++; end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rstn, wr, rd, addr, wdata} = '0;
    sync_n = 1'b1; n_mismatch = 0; tests_run = 0;
    offs = '{`CDV_OFF_CNT1, `CDV_OFF_PHASE, `CDV_OFF_CNT2, `CDV_OFF_CTRL, `CDV_OFF_DCC,
             `CDV_OFF_VDIV, `CDV_OFF_CLKIN, `CDV_OFF_SYNC};
    void'($urandom(32'h10d50c3a));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (offs[i]) rreg(offs[i], offs[i] == `CDV_OFF_VDIV ? 8'h02 : 8'h00);
    rreg(`CDV_OFF_UPDATE, 8'h00);
    rreg(10'h3ff, 8'h00);
    $display("test reset values done");
    foreach (offs[i]) begin
      v = 8'($urandom);
      wreg(offs[i], v);
      rreg(offs[i], v);
    end
    wreg(10'h3ff, 8'h5a);
    rreg(10'h3ff, 8'h00);
    $display("test readback done");
    for (int c = 0; c < 8; c++) begin
      cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'(c), 8'h00, 8'h00);
      if (c < 5) begin
        meas(1);
        chk(hi, ((c + 2) / 2) * 8);
        chk(lo, ((c + 2) - (c + 2) / 2) * 8);
      end else begin
        quiet(1);
        chk(tg, 0);
        chk(vco_div_out, 0);
      end
    end
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00);
    meas(1);
    chk(hi, 12);
    chk(lo, 12);
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00);
    quiet(1);
    chk(tg, 0);
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
    meas(1);
    chk(hi, 4);
    chk(lo, 4);
    $display("test vco divider done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1 || i == 7) ? 8'hff : 8'($urandom);
      d = (i < 6) ? 8'h01 : 8'h00;  // Last two with correction on, full ratio of 32 among them
      if (i % 2 == 1) cfg(v, 8'h00, 8'h28, d, 8'h00, 8'h01, 8'h00);
      else cfg(8'h00, v, 8'h18, d, 8'h00, 8'h01, 8'h00);
      meas(0);
      chk(hi, exp_hi(v, !d[0]));
      chk(lo, exp_lo(v, !d[0]));
      chk(hi + lo, (int'(v[3:0]) + int'(v[7:4]) + 2) * 8);
    end
    cfg(8'h00, 8'h30, 8'h18, 8'h00, 8'h00, 8'h01, 8'h00);
    meas(0);
    chk(hi, 16);
    chk(lo, 24);
    $display("test channel counts done");
    cfg(8'h00, 8'h00, 8'h0c, 8'h01, 8'h00, 8'h01, 8'h00);
    quiet(0);
    chk(tg, 0);
    chk(chan_out, 1);
    cfg(8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h01, 8'h00);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (20) @(posedge clk);
    quiet(0);
    chk(tg, 0);
    chk(chan_out, 1);
    @(posedge clk);
    sync_n <= 1'b1;
    meas(0);
    chk(hi, 8);
    cfg(8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h01, 8'h01);
    quiet(0);
    chk(tg, 0);
    chk(chan_out, 1);
    cfg(8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h01, 8'h00);
    meas(0);
    chk(lo, 8);
    // Sync ignored: divider keeps running with the pin low
    cfg(8'h00, 8'h00, 8'h18, 8'h01, 8'h00, 8'h01, 8'h00);
    sync_n <= 1'b0;
    quiet(0);
    chk(tg > 0, 1);
    @(posedge clk);
    sync_n <= 1'b1;
    // Phase offset only counts once update copies it
    cfg(8'h00, 8'h00, 8'h10, 8'h01, 8'h00, 8'h01, 8'h00);
    rel(lo);
    chk(lo < 40, 1);
    wreg(`CDV_OFF_PHASE, 8'h30);
    rel(hi);
    chk(hi, lo);
    wreg(`CDV_OFF_UPDATE, 8'h01);
    rel(hi);
    chk(hi - lo, 24);
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00);
    quiet(0);
    chk(tg, 0);
    chk({chan_out, vco_div_out}, 0);
    rreg(`CDV_OFF_STATUS, 8'h10);
    // Joint power-down of both sources stops the divided clock
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00);
    quiet(1);
    chk(tg, 0);
    chk(vco_div_out, 0);
    $display("test force sync and power-down done");
    final_report();
  end
endmodule
bind cdv_channel_divider cdv_channel_divider_props chk_u (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vco_in(vco_in), .ext_clk_in(ext_clk_in),
  .sync_n(sync_n), .vco_div_out(vco_div_out), .chan_out(chan_out));
